// file: rtl/fspa_flash_access.sv
// Sectored program flash access block: APB registers, erase/program sequencer, protection and tool link.
// Assumes mclk at 100 MHz, the tool link clocked by tool_serial_clock, and resetn driven by the tool in sessions.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module fspa_flash_access
   import fspa_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [31:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] flash_size_strap,
   input wire logic tool_connected,
   input wire logic prog_voltage_select,
   input wire logic tool_serial_clock,
   input wire logic tool_serial_data_i,
   output logic tool_serial_data_o,
   output logic tool_serial_data_oe,
   output logic app_pin_enable,
   output logic low_voltage_detector_en,
   output logic in_circuit_comm_mode
);
   typedef enum logic [1:0] {
      FSPA_IDLE = 2'b00,
      FSPA_ERASE = 2'b01,
      FSPA_UNPROT = 2'b10
   } fspa_state_t;
   // Reset release through two flops; all mclk logic uses the released copy.
   logic rst_s1_q, rstn_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_q <= 1'b0;
         rstn_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rstn_q <= rst_s1_q;
      end
   end
   // Link side signals that cross into mclk.
   logic rx_tog_l_q;
   logic [7:0] rx_hold_l_q;
   // Pins and the link toggle pass three flops; a change counts when the last two agree.
   logic [2:0] s1_q, s2_q, s3_q, filt_q;
   always_ff @(posedge mclk or negedge rstn_q) begin
      if (!rstn_q) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
         filt_q <= 3'h0;
      end else begin
         s1_q <= {rx_tog_l_q, tool_connected, prog_voltage_select};
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
      end
   end
   logic vpp_f, tool_f, rx_tog_f, rx_tog_seen_q, rx_event;
   assign vpp_f = filt_q[0];
   assign tool_f = filt_q[1];
   assign rx_tog_f = filt_q[2];
   assign rx_event = rx_tog_f != rx_tog_seen_q;
   // R12: tool selects communication mode
   assign in_circuit_comm_mode = vpp_f & tool_f;
   // R9: pins withdrawn once tool connected
   assign app_pin_enable = ~tool_f;
   // Register state.
   logic [7:0] ctrl_q;
   logic protect_q, lvd_opt_q, busy_q, err_q, rxnew_q, tx_tog_q, strap_done_q;
   logic [15:0] addr_q;
   logic [7:0] wdata_q, rdata_q, link_rx_q, link_tx_q;
   logic [1:0] nsect_q;
   fspa_state_t state_q;
   logic [13:0] erase_cnt_q, erase_end_q;
   logic [7:0] mem [0:FSPA_FLASH_BYTES-1];
   // APB decode; zero wait states, so every access phase completes at once.
   logic acc, wr, rd;
   logic [7:0] idx;
   logic hit_ctrl, hit_opt, hit_addr, hit_wdata, hit_rdata, hit_rx, hit_tx, mapped;
   assign acc = psel & penable;
   assign idx = paddr[9:2];
   assign hit_ctrl = idx == FSPA_IDX_CTRL;
   assign hit_opt = idx == FSPA_IDX_OPTION;
   assign hit_addr = idx == FSPA_IDX_ADDR;
   assign hit_wdata = idx == FSPA_IDX_WDATA;
   assign hit_rdata = idx == FSPA_IDX_RDATA;
   assign hit_rx = idx == FSPA_IDX_LINK_RX;
   assign hit_tx = idx == FSPA_IDX_LINK_TX;
   assign mapped = (paddr[31:10] == 22'h0) & (paddr[1:0] == 2'h0) &
      (hit_ctrl | hit_opt | hit_addr | hit_wdata | hit_rdata | hit_rx | hit_tx);
   assign wr = acc & pwrite & mapped & pstrb[0];
   assign rd = acc & ~pwrite & mapped;
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;
   // R3: sector 0 tops the map; sector 2 exists only above 8K.
   logic [1:0] op_sect;
   logic [13:0] op_idx;
   logic sect_avail, iap_mode;
   assign op_sect = (addr_q >= FSPA_SECT0_BASE) ? 2'd0 :
                    (addr_q >= FSPA_SECT1_BASE) ? 2'd1 :
                    (addr_q >= FSPA_FLASH_BASE) ? 2'd2 : 2'd3;
   assign op_idx = 14'(addr_q - FSPA_FLASH_BASE);
   // R2: sectors present by size
   assign sect_avail = op_sect < nsect_q;
   assign iap_mode = ctrl_q[FSPA_CTRL_IAP] & ~in_circuit_comm_mode;
   // Command decode from a control write; each command bit set in the write is decoded, so one write can carry several.
   logic cmd_prog, cmd_serase, cmd_merase, cmd_any, cmd_ok, op_start;
   assign cmd_prog = wr & hit_ctrl & pwdata[FSPA_CTRL_PROG];
   assign cmd_serase = wr & hit_ctrl & pwdata[FSPA_CTRL_SERASE];
   assign cmd_merase = wr & hit_ctrl & pwdata[FSPA_CTRL_MERASE];
   assign cmd_any = cmd_prog | cmd_serase | cmd_merase;
   // R15: programming voltage needed; R13: sector 0 closed in application mode
   assign cmd_ok = ~busy_q & vpp_f &
      (cmd_merase ? ~iap_mode : (sect_avail & ~(iap_mode & op_sect == 2'd0)));
   assign op_start = cmd_any & cmd_ok;
   // R5: clearing protection starts a full erase first
   logic unprot_req, opt_wr;
   assign opt_wr = wr & hit_opt & ~FSPA_IS_ROM;
   assign unprot_req = opt_wr & protect_q & ~pwdata[FSPA_OPT_PROTECT] & ~busy_q & vpp_f;
   // R6: protection from its option bit only
   logic protect_eff;
   assign protect_eff = FSPA_IS_ROM ? FSPA_ROM_PROTECT : protect_q;
   // R7: detector off while protected
   assign low_voltage_detector_en = lvd_opt_q & ~protect_eff;
   // Erase window: sector s occupies offsets (2-s)*4K up to the next sector.
   logic [13:0] sect_base;
   assign sect_base = (op_sect == 2'd0) ? 14'h2000 : (op_sect == 2'd1) ? 14'h1000 : 14'h0000;
   // Size strap caught once, on the first edge after reset release.
   always_ff @(posedge mclk or negedge rstn_q) begin
      if (!rstn_q) begin
         nsect_q <= 2'd1;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         nsect_q <= (flash_size_strap == 2'd0) ? 2'd1 : (flash_size_strap == 2'd1) ? 2'd2 : 2'd3;
      end
   end
   // Sequencer: erases walk one byte per cycle so the bus stays free meanwhile.
   always_ff @(posedge mclk or negedge rstn_q) begin
      if (!rstn_q) begin
         state_q <= FSPA_IDLE;
         erase_cnt_q <= 14'h0;
         erase_end_q <= 14'h0;
         protect_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         unique case (state_q)
            FSPA_IDLE: begin
               if (unprot_req) begin
                  state_q <= FSPA_UNPROT;
                  erase_cnt_q <= 14'h0;
                  erase_end_q <= FSPA_FLASH_LAST;
                  busy_q <= 1'b1;
               end else if (op_start & cmd_merase) begin
                  state_q <= FSPA_ERASE;
                  erase_cnt_q <= 14'h0;
                  erase_end_q <= FSPA_FLASH_LAST;
                  busy_q <= 1'b1;
               // R1: one sector erased alone
               end else if (op_start & cmd_serase) begin
                  state_q <= FSPA_ERASE;
                  erase_cnt_q <= sect_base;
                  erase_end_q <= sect_base + FSPA_SECT_LAST;
                  busy_q <= 1'b1;
               end else if (opt_wr & ~busy_q & ~protect_q) begin
                  protect_q <= pwdata[FSPA_OPT_PROTECT];
               end
            end
            FSPA_ERASE, FSPA_UNPROT: begin
               erase_cnt_q <= erase_cnt_q + 14'h1;
               if (erase_cnt_q == erase_end_q) begin
                  busy_q <= 1'b0;
                  state_q <= FSPA_IDLE;
                  // R5: protection drops only after the erase
                  if (state_q == FSPA_UNPROT) begin
                     protect_q <= 1'b0;
                  end
               end
            end
            default: state_q <= FSPA_IDLE;
         endcase
      end
   end
   // Array writes: erase fills with ones, a program can only clear bits.
   always_ff @(posedge mclk) begin
      if (busy_q) begin
         mem[erase_cnt_q] <= FSPA_ERASED;
      end else if (op_start & cmd_prog) begin
         // R16: refused writes never reach here
         mem[op_idx] <= mem[op_idx] & pwdata[15:8];
      end
   end
   // Read window; R4: blanked while the tool holds the part in protected mode.
   logic read_blocked;
   assign read_blocked = protect_eff & in_circuit_comm_mode;
   always_ff @(posedge mclk or negedge rstn_q) begin
      if (!rstn_q) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= (read_blocked | op_sect == 2'd3) ? 8'h00 : mem[op_idx];
      end
   end
   // Plain software registers and sticky flags; a set wins over a clear.
   always_ff @(posedge mclk or negedge rstn_q) begin
      if (!rstn_q) begin
         ctrl_q <= FSPA_CTRL_RESET;
         lvd_opt_q <= 1'b0;
         addr_q <= 16'h0000;
         wdata_q <= 8'h00;
         err_q <= 1'b0;
         rxnew_q <= 1'b0;
         link_rx_q <= 8'h00;
         rx_tog_seen_q <= 1'b0;
         link_tx_q <= 8'h00;
         tx_tog_q <= 1'b0;
      end else begin
         if (wr & hit_ctrl) begin
            ctrl_q[FSPA_CTRL_IAP] <= pwdata[FSPA_CTRL_IAP];
         end
         if (opt_wr) begin
            lvd_opt_q <= pwdata[FSPA_OPT_LVD];
         end
         if (wr & hit_addr) begin
            addr_q <= pwdata[15:0];
         end
         if (wr & hit_wdata) begin
            wdata_q <= pwdata[7:0];
         end
         // R16: refused command raises the error flag
         if (cmd_any & ~cmd_ok) begin
            err_q <= 1'b1;
         end else if (wr & hit_ctrl & pwdata[FSPA_CTRL_ERR]) begin
            err_q <= 1'b0;
         end
         rx_tog_seen_q <= rx_tog_f;
         if (rx_event) begin
            link_rx_q <= rx_hold_l_q;
            rxnew_q <= 1'b1;
         end else if (rd & hit_rx) begin
            rxnew_q <= 1'b0;
         end
         if (wr & hit_tx) begin
            link_tx_q <= pwdata[7:0];
            tx_tog_q <= ~tx_tog_q;
         end
      end
   end
   // R14: control/status word seen by software
   logic [7:0] ctrl_view;
   assign ctrl_view = {in_circuit_comm_mode, rxnew_q, err_q, busy_q, ctrl_q[FSPA_CTRL_IAP], 3'b000};
   assign prdata = ~rd ? 32'h0 :
      hit_ctrl ? {24'h0, ctrl_view} :
      hit_opt ? {30'h0, lvd_opt_q, protect_eff} :
      hit_addr ? {16'h0, addr_q} :
      hit_wdata ? {24'h0, wdata_q} :
      hit_rdata ? {24'h0, rdata_q} :
      hit_rx ? {24'h0, link_rx_q} : {24'h0, link_tx_q};
   // Link domain: reset release and quasi-static levels through flops on the tool clock.
   logic lrst_s1_q, lrstn_q;
   always_ff @(posedge tool_serial_clock or negedge resetn) begin
      if (!resetn) begin
         lrst_s1_q <= 1'b0;
         lrstn_q <= 1'b0;
      end else begin
         lrst_s1_q <= 1'b1;
         lrstn_q <= lrst_s1_q;
      end
   end
   // The reply byte is stable long before its toggle is seen, so only the toggle is synchronised.
   logic prot_l1_q, prot_l2_q, prot_l3_q, tx_l1_q, tx_l2_q, tx_l3_q;
   logic [3:0] bit_l_q;
   logic [7:0] shift_l_q, tx_l_q, out_l_q;
   always_ff @(posedge tool_serial_clock or negedge lrstn_q) begin
      if (!lrstn_q) begin
         prot_l1_q <= 1'b0;
         prot_l2_q <= 1'b0;
         prot_l3_q <= 1'b0;
         tx_l1_q <= 1'b0;
         tx_l2_q <= 1'b0;
         tx_l3_q <= 1'b0;
         tx_l_q <= 8'h00;
         bit_l_q <= 4'h0;
         shift_l_q <= 8'h00;
         out_l_q <= 8'h00;
         rx_hold_l_q <= 8'h00;
         rx_tog_l_q <= 1'b0;
      end else begin
         prot_l1_q <= protect_eff;
         prot_l2_q <= prot_l1_q;
         prot_l3_q <= prot_l2_q;
         tx_l1_q <= tx_tog_q;
         tx_l2_q <= tx_l1_q;
         tx_l3_q <= tx_l2_q;
         if (tx_l2_q != tx_l3_q) begin
            tx_l_q <= link_tx_q;
         end
         bit_l_q <= bit_l_q + 4'h1;
         if (bit_l_q < FSPA_FIRST_TX_BIT) begin
            shift_l_q <= {shift_l_q[6:0], tool_serial_data_i};
         end else begin
            out_l_q <= {out_l_q[6:0], 1'b0};
         end
         if (bit_l_q == FSPA_LAST_RX_BIT) begin
            rx_hold_l_q <= {shift_l_q[6:0], tool_serial_data_i};
            rx_tog_l_q <= ~rx_tog_l_q;
            out_l_q <= tx_l_q;
         end
      end
   end
   // R4: no reply while either late flop says protected, so a crossing glitch never opens it.
   assign tool_serial_data_oe = bit_l_q[3] & ~prot_l2_q & ~prot_l3_q;
   // R8: shared data line
   assign tool_serial_data_o = out_l_q[7];
   // Checks on the rules this block keeps.
   sequence s_unprot_run;
      (state_q == FSPA_UNPROT) && busy_q && protect_q;
   endsequence
   property p_unprot_erase;
      @(posedge mclk) disable iff (!rstn_q) unprot_req |=> s_unprot_run;
   endproperty
   a_unprot_erase: assert property (p_unprot_erase) else $error("unprotect did not start erase"); // R5
   property p_protect_drop;
      @(posedge mclk) disable iff (!rstn_q) $fell(protect_q) |-> $past(state_q) == FSPA_UNPROT;
   endproperty
   a_protect_drop: assert property (p_protect_drop) else $error("protection dropped without erase"); // R5
   property p_iap_s0;
      @(posedge mclk) disable iff (!rstn_q) (cmd_any && iap_mode && op_sect == 2'd0 && !busy_q) |=> err_q && !busy_q;
   endproperty
   a_iap_s0: assert property (p_iap_s0) else $error("sector 0 changed in application mode"); // R13
   property p_lvd;
      @(posedge mclk) disable iff (!rstn_q) protect_eff |-> !low_voltage_detector_en;
   endproperty
   a_lvd: assert property (p_lvd) else $error("detector on while protected"); // R7
   property p_read_block;
      @(posedge mclk) disable iff (!rstn_q) read_blocked ##1 read_blocked |-> rdata_q == 8'h00;
   endproperty
   a_read_block: assert property (p_read_block) else $error("protected read returned data"); // R4
   property p_pins;
      @(posedge mclk) disable iff (!rstn_q) (s2_q[1] && s3_q[1]) |=> !app_pin_enable;
   endproperty
   a_pins: assert property (p_pins) else $error("pins kept by application"); // R9
   property p_size;
      @(posedge mclk) disable iff (!rstn_q) (strap_done_q && nsect_q == 2'd1 && cmd_serase && op_sect == 2'd1
         && !busy_q) |=> err_q && state_q == FSPA_IDLE;
   endproperty
   a_size: assert property (p_size) else $error("absent sector accepted"); // R2
   property p_vpp;
      @(posedge mclk) disable iff (!rstn_q) (cmd_any && !vpp_f && !busy_q) |=> !busy_q && err_q;
   endproperty
   a_vpp: assert property (p_vpp) else $error("operation without programming voltage"); // R15
   property p_sect_erase;
      @(posedge mclk) disable iff (!rstn_q) (op_start && cmd_serase && op_sect == 2'd1)
         |=> erase_cnt_q == 14'h1000 && erase_end_q == 14'h1FFF;
   endproperty
   a_sect_erase: assert property (p_sect_erase) else $error("erase window wrong"); // R1
   property p_link_quiet;
      @(posedge tool_serial_clock) disable iff (!lrstn_q) prot_l2_q |-> !tool_serial_data_oe;
   endproperty
   a_link_quiet: assert property (p_link_quiet) else $error("reply driven while protected"); // R4
endmodule // fspa_flash_access
`default_nettype wire

// file: rtl/fspa_pkg.sv
// Package for the sectored program flash access block: register map, fields, sector map and timing.
// Assumes a 32-bit APB slave port with one aligned word per register, byte address = index * 4.
// How it works
// R1: Up to three user sectors, each erased alone without touching the others.
// R2: 4K part has sector 0, 8K adds sector 1, larger adds sector 2.
// R3: Sectors 0 and 1 are 4 Kbytes at the top; sector 0 is F000h-FFFFh.
// R4: With read-out protection on, no external path may return flash contents.
// R5: Removing protection first erases the whole program memory automatically.
// R6: Protection changes only through its option bit; a masked-ROM build fixes it.
// R7: The low-voltage detector is disabled while read-out protection is on.
// R8: Tool port uses reset, ground, serial clock, serial data, voltage select, optional clock.
// R9: Once the tool is connected the serial pins are withdrawn from the application.
// R10: The tool alone drives device reset during a programming session.
// R11: Without an application clock the tool drives the main clock input.
// R12: The tool switches the device to communication mode; RAM code runs programming.
// R13: In application programming mode every sector but sector 0 may be changed.
// R14: Control/status register at 0029h, 8 bits, reset 00h, steers program and erase.
// R15: Erase by block or sector, program by byte, only with programming voltage present.
// R16: Sector 0 write or erase in application mode is ignored, contents unchanged.
package fspa_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] FSPA_IDX_CTRL = 8'h29;
   localparam logic [7:0] FSPA_IDX_OPTION = 8'h2A;
   localparam logic [7:0] FSPA_IDX_ADDR = 8'h2B;
   localparam logic [7:0] FSPA_IDX_WDATA = 8'h2C;
   localparam logic [7:0] FSPA_IDX_RDATA = 8'h2D;
   localparam logic [7:0] FSPA_IDX_LINK_RX = 8'h2E;
   localparam logic [7:0] FSPA_IDX_LINK_TX = 8'h2F;
   localparam logic [7:0] FSPA_CTRL_RESET = 8'h00;
   // Control/status field positions.
   localparam int FSPA_CTRL_PROG = 0;
   localparam int FSPA_CTRL_SERASE = 1;
   localparam int FSPA_CTRL_MERASE = 2;
   localparam int FSPA_CTRL_IAP = 3;
   localparam int FSPA_CTRL_BUSY = 4;
   localparam int FSPA_CTRL_ERR = 5;
   localparam int FSPA_CTRL_RXNEW = 6;
   localparam int FSPA_CTRL_COMM = 7;
   // Option field positions.
   localparam int FSPA_OPT_PROTECT = 0;
   localparam int FSPA_OPT_LVD = 1;
   // Masked-ROM build: protection fixed at manufacture.
   localparam logic FSPA_IS_ROM = 1'b0;
   localparam logic FSPA_ROM_PROTECT = 1'b0;
   // Sector map: three 4 Kbyte sectors from D000h, sector 0 at F000h.
   localparam logic [15:0] FSPA_FLASH_BASE = 16'hD000;
   localparam logic [15:0] FSPA_SECT0_BASE = 16'hF000;
   localparam logic [15:0] FSPA_SECT1_BASE = 16'hE000;
   localparam int FSPA_SECT_BYTES = 4096;
   localparam int FSPA_FLASH_BYTES = 12288;
   localparam logic [13:0] FSPA_SECT_LAST = 14'h0FFF;
   localparam logic [13:0] FSPA_FLASH_LAST = 14'h2FFF;
   localparam logic [7:0] FSPA_ERASED = 8'hFF;
   // Link frame: eight bits in, then eight bits out.
   localparam logic [3:0] FSPA_LAST_RX_BIT = 4'h7;
   localparam logic [3:0] FSPA_FIRST_TX_BIT = 4'h8;
endpackage : fspa_pkg

// file: verification/fspa_tool_model.sv
// Programming tool model: owns device reset, tool presence, programming voltage and the serial link.
// Assumes the device samples link data on the rising tool clock and drives its reply from a link-domain flop.
`timescale 1ns/1ns
`default_nettype none
module fspa_tool_model (
   input wire logic mclk,
   output logic resetn,
   output logic tool_connected,
   output logic prog_voltage_select,
   output logic tool_serial_clock,
   output logic tool_serial_data_i,
   input wire logic tool_serial_data_o,
   input wire logic tool_serial_data_oe
);
   logic drive_q, bit_q, last_q;
   // shared data line
   // A released line toggles at each rising link edge, so a stale level can never pass for a reply.
   assign tool_serial_data_i = tool_serial_data_oe ? tool_serial_data_o : (drive_q ? bit_q : ~last_q);
   // Remember the line level at every rising link edge.
   always @(posedge tool_serial_clock) begin
      last_q <= tool_serial_data_i;
   end
   // The link clock stands low between frames.
   initial begin
      resetn = 1'b0;
      tool_connected = 1'b0;
      prog_voltage_select = 1'b0;
      tool_serial_clock = 1'b0;
      drive_q = 1'b0;
      bit_q = 1'b0;
      last_q = 1'b0;
   end
   task automatic reset_dut();
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask
   // plug and voltage
   // Eight cycles cover the device's pin filters.
   task automatic plug(input logic con, input logic vpp);
      @(posedge mclk);
      tool_connected <= con;
      prog_voltage_select <= vpp;
      repeat (8) @(posedge mclk);
   endtask
   // One link clock period of 30 ns.
   task automatic pulse();
      #15 tool_serial_clock = 1'b1;
      #15 tool_serial_clock = 1'b0;
   endtask
   // The 4 ns offset keeps link edges away from the core clock edges.
   task automatic link_idle();
      #4;
      pulse();
      pulse();
   endtask
   // Eight bits out MSB first, then eight reply bits sampled just before each rising edge.
   task automatic frame(input logic [7:0] tx, output logic [7:0] rx, output logic oe_any);
      oe_any = 1'b0;
      #4;
      for (int i = 7; i >= 0; i--) begin
         bit_q = tx[i];
         drive_q = 1'b1;
         pulse();
      end
      drive_q = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #15;
         rx[i] = tool_serial_data_i;
         oe_any = oe_any | tool_serial_data_oe;
         tool_serial_clock = 1'b1;
         #15 tool_serial_clock = 1'b0;
      end
   endtask
endmodule // fspa_tool_model
`default_nettype wire

// file: verification/tb.sv
// Testbench for the flash access block: APB register tasks and sequences with expected values.
// Assumes the tool model owns reset and the link; flash bytes are erased before they are read.
`timescale 1ns/1ns
`default_nettype none
module tb
   import fspa_pkg::*;
;
   logic mclk, resetn, psel, penable, pwrite, pready, pslverr, err, oe_any;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [1:0] flash_size_strap;
   logic tool_connected, prog_voltage_select, tool_serial_clock, tool_serial_data_i, tool_serial_data_o;
   logic tool_serial_data_oe, app_pin_enable, low_voltage_detector_en, in_circuit_comm_mode;
   logic [7:0] rx;
   int failures = 0;
   int total_checks = 0;
   fspa_flash_access u_dut (.mclk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .flash_size_strap, .tool_connected, .prog_voltage_select, .tool_serial_clock, .tool_serial_data_i,
      .tool_serial_data_o, .tool_serial_data_oe, .app_pin_enable, .low_voltage_detector_en, .in_circuit_comm_mode);
   fspa_tool_model u_tool (.mclk, .resetn, .tool_connected, .prog_voltage_select, .tool_serial_clock,
      .tool_serial_data_i, .tool_serial_data_o, .tool_serial_data_oe);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // The run needs about 25k cycles; this cuts a hang at 100k.
   initial begin
      #1000000;
      failures++;
      stop_test();
   end
   task automatic stop_test();
      if (failures == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) begin
         failures++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
   endtask
   task automatic rreg(input logic [7:0] idx, input logic [31:0] exp, input string what);
      apb(1'b0, idx, 32'h0);
      chk(what, rd, exp);
   endtask
   task automatic rd_mem(input logic [15:0] addr, input logic [31:0] exp);
      wreg(FSPA_IDX_ADDR, {16'h0, addr});
      rreg(FSPA_IDX_RDATA, exp, "flash byte");
   endtask
   // Polls a register until the given bit is clear; after 8000 polls the test fails and stops.
   task automatic wait_clear(input logic [7:0] idx, input int pos);
      int n;
      n = 0;
      do begin
         apb(1'b0, idx, 32'h0);
         n++;
      end while (rd[pos] !== 1'b0 && n < 8000);
      if (rd[pos] !== 1'b0) begin
         failures++;
         stop_test();
      end
   endtask
   task automatic flash_op(input logic [15:0] addr, input logic [31:0] cmd);
      wreg(FSPA_IDX_ADDR, {16'h0, addr});
      wreg(FSPA_IDX_CTRL, cmd);
      wait_clear(FSPA_IDX_CTRL, FSPA_CTRL_BUSY);
   endtask
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'hF;
      flash_size_strap = 2'h0;
      u_tool.reset_dut();
      rreg(FSPA_IDX_CTRL, 32'h00, "control after reset");
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      wreg(FSPA_IDX_WDATA, 32'h5A);
      rreg(FSPA_IDX_WDATA, 32'h5A, "write data store");
      chk("app pins free", {31'h0, app_pin_enable}, 32'h1);
      u_tool.plug(1'b1, 1'b1);
      chk("app pins taken", {31'h0, app_pin_enable}, 32'h0);
      chk("comm mode", {31'h0, in_circuit_comm_mode}, 32'h1);
      flash_op(16'hE000, 32'h02);
      rreg(FSPA_IDX_CTRL, 32'hA0, "absent sector on 4K");
      @(posedge mclk);
      flash_size_strap <= 2'h2;
      u_tool.reset_dut();
      rreg(FSPA_IDX_CTRL, 32'h80, "control after second reset");
      flash_op(16'hE000, 32'h02);
      rd_mem(16'hE010, 32'hFF);
      flash_op(16'hE010, 32'hA501);
      flash_op(16'hE010, 32'h0F01);
      rd_mem(16'hE010, 32'h05);
      flash_op(16'hD000, 32'h02);
      rd_mem(16'hE010, 32'h05);
      rd_mem(16'hD123, 32'hFF);
      flash_op(16'hF000, 32'h02);
      flash_op(16'hFFFF, 32'h3C01);
      rd_mem(16'hFFFF, 32'h3C);
      u_tool.plug(1'b1, 1'b0);
      flash_op(16'hE010, 32'h0001);
      rreg(FSPA_IDX_CTRL, 32'h20, "program without voltage");
      rd_mem(16'hE010, 32'h05);
      wreg(FSPA_IDX_CTRL, 32'h20);
      u_tool.plug(1'b0, 1'b1);
      chk("app pins back", {31'h0, app_pin_enable}, 32'h1);
      wreg(FSPA_IDX_CTRL, 32'h08);
      flash_op(16'hFFFF, 32'h0009);
      rreg(FSPA_IDX_CTRL, 32'h28, "sector 0 program refused");
      rd_mem(16'hFFFF, 32'h3C);
      wreg(FSPA_IDX_CTRL, 32'h28);
      flash_op(16'hF000, 32'h0A);
      rd_mem(16'hFFFF, 32'h3C);
      wreg(FSPA_IDX_CTRL, 32'h28);
      flash_op(16'hE000, 32'h0C);
      rreg(FSPA_IDX_CTRL, 32'h28, "mass erase refused");
      wreg(FSPA_IDX_CTRL, 32'h28);
      flash_op(16'hE010, 32'h0009);
      rreg(FSPA_IDX_CTRL, 32'h08, "sector 1 program allowed");
      rd_mem(16'hE010, 32'h00);
      wreg(FSPA_IDX_CTRL, 32'h00);
      u_tool.plug(1'b1, 1'b1);
      u_tool.link_idle();
      wreg(FSPA_IDX_LINK_TX, 32'h96);
      u_tool.frame(8'h3C, rx, oe_any);
      chk("link reply", {24'h0, rx}, 32'h96);
      chk("reply driven", {31'h0, oe_any}, 32'h1);
      repeat (10) @(posedge mclk);
      rreg(FSPA_IDX_CTRL, 32'hC0, "byte received flag");
      rreg(FSPA_IDX_LINK_RX, 32'h3C, "received byte");
      rreg(FSPA_IDX_CTRL, 32'h80, "received flag cleared");
      wreg(FSPA_IDX_OPTION, 32'h02);
      @(posedge mclk);
      chk("detector on", {31'h0, low_voltage_detector_en}, 32'h1);
      wreg(FSPA_IDX_OPTION, 32'h03);
      @(posedge mclk);
      chk("detector off when protected", {31'h0, low_voltage_detector_en}, 32'h0);
      rd_mem(16'hFFFF, 32'h00);
      u_tool.frame(8'h11, rx, oe_any);
      chk("protected reply withheld", {31'h0, oe_any}, 32'h0);
      u_tool.plug(1'b1, 1'b0);
      wreg(FSPA_IDX_OPTION, 32'h00);
      rreg(FSPA_IDX_OPTION, 32'h01, "protection kept without voltage");
      u_tool.plug(1'b1, 1'b1);
      wreg(FSPA_IDX_OPTION, 32'h00);
      wait_clear(FSPA_IDX_OPTION, FSPA_OPT_PROTECT);
      rreg(FSPA_IDX_OPTION, 32'h00, "protection removed");
      rd_mem(16'hFFFF, 32'hFF);
      rd_mem(16'hE010, 32'hFF);
      stop_test();
   end
endmodule // tb
`default_nettype wire
